/* File: rtl/device_power_mode_manager.sv */
// Device power mode manager: command handling, mode tracking, replies, state save
`timescale 1ns/1ns
module device_power_mode_manager #(
  parameter logic [4:0] SUPPORT_MASK = 5'b11111,
  parameter int         CAP_LEN      = 43,
  parameter logic [CAP_LEN*8-1:0] CAP_TAG = "pwr(run(B120 L0) susp(5) ssave() psave(16))"
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  own_addr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_first,
  input  wire logic        rx_last,
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  output logic             tx_last,
  input  wire logic        tx_ready,
  input  wire logic        app_busy,
  input  wire logic        auto_req,
  input  wire logic [7:0]  auto_mode,
  input  wire logic        wake_event,
  input  wire logic        save_done,
  input  wire logic        state_at_host,
  input  wire logic        restore_ok,
  input  wire logic        restore_fail,
  input  wire logic        need_power,
  input  wire logic [15:0] bus_power_usage,
  input  wire logic [15:0] line_power_usage,
  input  wire logic [5:0]  cap_index,
  output logic [7:0]       cap_char,
  output logic [7:0]       operating_mode_code,
  output logic             save_req,
  output logic             restore_busy,
  output logic             restore_revert
);
  import pwr_mgmt_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_RESTORE} mgr_state_e;

  typedef struct packed {
    mgr_state_e st;
    logic [7:0] mode;
    logic       pend;
    logic [7:0] pend_mode;
    logic       want_reply;
    logic       want_status;
    logic       want_read;
    logic       want_power;
    logic       power_asked;
    logic       revert;
    logic [7:0] cap_char;
  } mgr_s;

  // Lowest power supported mode at power up, shutdown and power off excluded as they need a command
  localparam logic [7:0] RESET_MODE = SUPPORT_MASK[2] ? MODE_SUSPEND :
                                      SUPPORT_MASK[1] ? MODE_STANDBY : MODE_RUN;

  // Power up image: nothing waiting, nothing owed to the host
  localparam mgr_s MGR_RESET = '{
    st:          ST_IDLE,
    mode:        RESET_MODE,
    pend:        1'b0,
    pend_mode:   MODE_RUN,
    want_reply:  1'b0,
    want_status: 1'b0,
    want_read:   1'b0,
    want_power:  1'b0,
    power_asked: 1'b0,
    revert:      1'b0,
    cap_char:    ZERO_BYTE
  };

  mgr_s       mgr_reg;
  mgr_s       mgr_next;
  logic       cmd_valid;
  logic [7:0] cmd_code;
  logic       tx_busy;
  logic       tx_start;
  msg_kind_e  tx_kind;
  logic [7:0] target;
  logic       target_ok;
  logic       cmd_query;
  logic       cmd_restart;
  logic       idle_quiet;
  logic       auto_ok;
  logic       wake_ok;
  logic       power_ask;
  logic [7:0] cap_pick;

  cmd_frame_decoder u_decoder (
    .clk       (clk),
    .rst       (rst),
    .rx_valid  (rx_valid),
    .rx_byte   (rx_byte),
    .rx_first  (rx_first),
    .rx_last   (rx_last),
    .own_addr  (own_addr),
    .cmd_valid (cmd_valid),
    .cmd_code  (cmd_code)
  );

  // Supported mode lookup; unsupported standby runs as run, shutdown as suspend
  always_comb begin
    target    = cmd_code;
    target_ok = 1'b0;
    unique case (cmd_code)
      CMD_RUN,
      CMD_SUSPEND,
      CMD_POWER_OFF: begin
        target_ok = SUPPORT_MASK[cmd_code[2:0]];
      end
      CMD_STANDBY: begin
        if (SUPPORT_MASK[cmd_code[2:0]]) begin
          target_ok = 1'b1;
        end else if (SUPPORT_MASK[0]) begin
          target    = MODE_RUN;
          target_ok = 1'b1;
        end
      end
      CMD_SHUTDOWN: begin
        if (SUPPORT_MASK[cmd_code[2:0]]) begin
          target_ok = 1'b1;
        end else if (SUPPORT_MASK[2]) begin
          target    = MODE_SUSPEND;
          target_ok = 1'b1;
        end
      end
      default: begin
        // Restart and query name no mode; unknown codes are ignored
        target_ok = 1'b0;
      end
    endcase
  end

  // One message at a time; failure report outranks everything
  always_comb begin
    tx_start = 1'b0;
    tx_kind  = MSG_POWER_REQ;
    if (!tx_busy) begin
      if (mgr_reg.want_status) begin
        tx_start = 1'b1;
        tx_kind  = MSG_STATUS;
      end else if (mgr_reg.want_reply) begin
        tx_start = 1'b1;
        tx_kind  = MSG_REPLY;
      end else if (mgr_reg.want_read) begin
        tx_start = 1'b1;
        tx_kind  = MSG_READ_REQ;
      end else if (mgr_reg.want_power) begin
        tx_start = 1'b1;
        tx_kind  = MSG_POWER_REQ;
      end
    end
  end

  // Out of range index reads a zero byte rather than unknown bits
  always_comb begin
    cap_pick = ZERO_BYTE;
    if (int'(cap_index) < CAP_LEN) begin
      cap_pick = CAP_TAG[8*(CAP_LEN-1-int'(cap_index)) +: 8];
    end
  end

  // A landing command blocks own moves in that cycle
  always_comb begin
    cmd_query   = cmd_valid && (cmd_code == CMD_QUERY);
    cmd_restart = cmd_valid && (cmd_code == CMD_RESTART) && (mgr_reg.st == ST_IDLE);
    idle_quiet  = (mgr_reg.st == ST_IDLE) && !cmd_valid;
    auto_ok     = idle_quiet && !mgr_reg.pend && auto_req && (auto_mode > mgr_reg.mode) &&
                  (auto_mode <= MODE_SHUTDOWN) && SUPPORT_MASK[auto_mode[1:0]];
    wake_ok     = idle_quiet && !mgr_reg.pend && wake_event && (mgr_reg.mode == MODE_SUSPEND);
    power_ask   = (mgr_reg.mode == MODE_OFF_READY) && need_power && !mgr_reg.power_asked;
  end

  always_comb begin
    mgr_next          = mgr_reg;
    mgr_next.revert   = 1'b0;
    mgr_next.cap_char = cap_pick;

    // Sent flags drop; a new request in the same cycle is kept below
    if (tx_start) begin
      unique case (tx_kind)
        MSG_STATUS:    mgr_next.want_status = 1'b0;
        MSG_REPLY:     mgr_next.want_reply  = 1'b0;
        MSG_READ_REQ:  mgr_next.want_read   = 1'b0;
        MSG_POWER_REQ: mgr_next.want_power  = 1'b0;
      endcase
    end

    if (cmd_query) begin
      mgr_next.want_reply = 1'b1;
    end else if (cmd_restart) begin
      mgr_next.pend        = 1'b0;
      mgr_next.power_asked = 1'b0;
      if (state_at_host) begin
        mgr_next.want_read = 1'b1;
        mgr_next.st        = ST_RESTORE;
      end else begin
        mgr_next.mode = MODE_RUN;
      end
    end else if (cmd_valid && target_ok) begin
      // Latest command replaces any that is still waiting
      mgr_next.pend        = 1'b1;
      mgr_next.pend_mode   = target;
      mgr_next.power_asked = 1'b0;
    end

    unique case (mgr_reg.st)
      ST_IDLE: begin
        if (idle_quiet && mgr_reg.pend && !app_busy) begin
          mgr_next.pend = 1'b0;
          if (mgr_reg.pend_mode >= MODE_SUSPEND && mgr_reg.pend_mode != mgr_reg.mode) begin
            mgr_next.st = ST_SAVE;
          end else begin
            mgr_next.mode = mgr_reg.pend_mode;
          end
        end else if (auto_ok) begin
          // Own decision, only ever toward less power
          mgr_next.pend      = 1'b1;
          mgr_next.pend_mode = auto_mode;
        end else if (wake_ok) begin
          // Shutdown is deliberately absent: only a command lifts it
          mgr_next.mode = MODE_RUN;
        end
      end
      ST_SAVE: begin
        if (save_done) begin
          mgr_next.mode = mgr_reg.pend_mode;
          mgr_next.st   = ST_IDLE;
        end
      end
      ST_RESTORE: begin
        if (restore_ok) begin
          mgr_next.mode = MODE_RUN;
          mgr_next.st   = ST_IDLE;
        end else if (restore_fail) begin
          // Address and interface untouched; the rest reverted by the application
          mgr_next.revert      = 1'b1;
          mgr_next.want_status = 1'b1;
          mgr_next.st          = ST_IDLE;
        end
      end
      default: mgr_next.st = ST_IDLE;
    endcase

    // Ask once per power off advisory for power to finish work
    if (power_ask) begin
      mgr_next.want_power  = 1'b1;
      mgr_next.power_asked = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mgr_reg <= MGR_RESET;
    end else begin
      mgr_reg <= mgr_next;
    end
  end

  msg_framer u_framer (
    .clk              (clk),
    .rst              (rst),
    .start            (tx_start),
    .kind             (tx_kind),
    .own_addr         (own_addr),
    .mode             (mgr_reg.mode),
    .bus_power_usage  (bus_power_usage),
    .line_power_usage (line_power_usage),
    .tx_ready         (tx_ready),
    .tx_valid         (tx_valid),
    .tx_byte          (tx_byte),
    .tx_last          (tx_last),
    .busy             (tx_busy)
  );

  assign operating_mode_code = mgr_reg.mode;
  assign save_req            = (mgr_reg.st == ST_SAVE);
  assign restore_busy        = (mgr_reg.st == ST_RESTORE);
  assign restore_revert      = mgr_reg.revert;
  assign cap_char            = mgr_reg.cap_char;
endmodule : device_power_mode_manager

/* File: inc/pwr_mgmt_pkg.sv */
// Shared constants and types for the device power mode manager
package pwr_mgmt_pkg;
  localparam logic [7:0]  HOST_ADDR      = 8'h50;
  localparam logic [7:0]  LEN_CMD        = 8'h82;
  localparam logic [7:0]  OP_CMD         = 8'hF6;
  localparam logic [7:0]  LEN_REPLY      = 8'h87;
  localparam logic [7:0]  OP_REPLY       = 8'hE6;
  localparam logic [7:0]  LEN_STATUS     = 8'h85;
  localparam logic [7:0]  OP_STATUS      = 8'hA2;
  localparam logic [7:0]  STATUS_LOST    = 8'h03;
  localparam logic [7:0]  LEN_RES_REQ    = 8'h82;
  localparam logic [7:0]  OP_RES_REQ     = 8'hE5;
  localparam logic [7:0]  RES_READ       = 8'h05;
  localparam logic [7:0]  RES_POWER      = 8'h06;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;
  localparam logic [15:0] POWER_UNKNOWN  = 16'hFFFF;
  // Command codes
  localparam logic [7:0]  CMD_RUN        = 8'h00;
  localparam logic [7:0]  CMD_STANDBY    = 8'h01;
  localparam logic [7:0]  CMD_SUSPEND    = 8'h02;
  localparam logic [7:0]  CMD_SHUTDOWN   = 8'h03;
  localparam logic [7:0]  CMD_POWER_OFF  = 8'h04;
  localparam logic [7:0]  CMD_RESTART    = 8'h05;
  localparam logic [7:0]  CMD_QUERY      = 8'h06;
  // Operating mode codes, rising code means less power
  localparam logic [7:0]  MODE_RUN       = 8'h00;
  localparam logic [7:0]  MODE_STANDBY   = 8'h01;
  localparam logic [7:0]  MODE_SUSPEND   = 8'h02;
  localparam logic [7:0]  MODE_SHUTDOWN  = 8'h03;
  localparam logic [7:0]  MODE_OFF_READY = 8'h04;
  // Frame positions and lengths
  localparam logic [3:0]  IDX_DEST       = 4'h0;
  localparam logic [3:0]  IDX_SRC        = 4'h1;
  localparam logic [3:0]  IDX_LEN        = 4'h2;
  localparam logic [3:0]  IDX_OP         = 4'h3;
  localparam logic [3:0]  IDX_CODE       = 4'h4;
  localparam logic [3:0]  IDX_CSUM       = 4'h5;
  localparam logic [3:0]  LEN_REPLY_MSG  = 4'hB;
  localparam logic [3:0]  LEN_STATUS_MSG = 4'h9;
  localparam logic [3:0]  LEN_REQ_MSG    = 4'h6;
  localparam int          BODY_BYTES     = 10;

  typedef enum logic [1:0] {MSG_REPLY, MSG_STATUS, MSG_READ_REQ, MSG_POWER_REQ} msg_kind_e;
endpackage : pwr_mgmt_pkg

/* File: rtl/cmd_frame_decoder.sv */
// Decoder for incoming power management command frames
`timescale 1ns/1ns
module cmd_frame_decoder (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_first,
  input  wire logic       rx_last,
  input  wire logic [7:0] own_addr,
  output logic            cmd_valid,
  output logic [7:0]      cmd_code
);
  import pwr_mgmt_pkg::*;

  typedef struct packed {
    logic [3:0] idx;
    logic       ok;
    logic [7:0] xsum;
    logic [7:0] code;
    logic       valid;
  } dec_s;

  dec_s dec_reg;
  dec_s dec_next;
  logic [3:0] pos;
  logic       match;

  always_comb begin
    dec_next       = dec_reg;
    dec_next.valid = 1'b0;
    pos            = rx_first ? IDX_DEST : dec_reg.idx;
    match          = rx_first ? 1'b1 : dec_reg.ok;
    if (rx_valid) begin
      unique case (pos)
        IDX_DEST: match = match && (rx_byte == own_addr);
        IDX_SRC:  match = match && (rx_byte == HOST_ADDR);
        IDX_LEN:  match = match && (rx_byte == LEN_CMD);
        IDX_OP:   match = match && (rx_byte == OP_CMD);
        IDX_CODE: dec_next.code = rx_byte;
        IDX_CSUM: match = match && ((dec_reg.xsum ^ rx_byte) == ZERO_BYTE) && rx_last;
        default:  match = 1'b0;
      endcase
      dec_next.ok    = match;
      dec_next.xsum  = (rx_first ? ZERO_BYTE : dec_reg.xsum) ^ rx_byte;
      dec_next.idx   = (pos == IDX_CSUM + 4'h1) ? pos : pos + 4'h1;
      dec_next.valid = match && (pos == IDX_CSUM);
      if (rx_last) begin
        dec_next.idx = IDX_DEST;
        dec_next.ok  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_reg <= '{idx: 4'h0, ok: 1'b1, xsum: 8'h00, code: 8'h00, valid: 1'b0};
    end else begin
      dec_reg <= dec_next;
    end
  end

  assign cmd_valid = dec_reg.valid;
  assign cmd_code  = dec_reg.code;
endmodule : cmd_frame_decoder

/* File: rtl/msg_framer.sv */
// Serializer for outgoing device messages
`timescale 1ns/1ns
module msg_framer (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     start,
  input  wire pwr_mgmt_pkg::msg_kind_e  kind,
  input  wire logic [7:0]               own_addr,
  input  wire logic [7:0]               mode,
  input  wire logic [15:0]              bus_power_usage,
  input  wire logic [15:0]              line_power_usage,
  input  wire logic                     tx_ready,
  output logic                          tx_valid,
  output logic [7:0]                    tx_byte,
  output logic                          tx_last,
  output logic                          busy
);
  import pwr_mgmt_pkg::*;

  typedef struct packed {
    logic                    active;
    logic [3:0]              idx;
    logic [3:0]              len;
    logic [BODY_BYTES*8-1:0] body;
    logic [7:0]              xsum;
    logic [7:0]              cur;
  } frm_s;

  frm_s frm_reg;
  frm_s frm_next;
  logic [BODY_BYTES*8-1:0] body_new;
  logic [3:0]              len_new;
  logic                    fire;

  always_comb begin
    unique case (kind)
      MSG_REPLY: begin
        body_new = {HOST_ADDR, own_addr, LEN_REPLY, OP_REPLY, ZERO_BYTE, mode,
                    bus_power_usage, line_power_usage};
        len_new  = LEN_REPLY_MSG;
      end
      MSG_STATUS: begin
        body_new = {HOST_ADDR, own_addr, LEN_STATUS, OP_STATUS, ZERO_BYTE, STATUS_LOST,
                    ZERO_BYTE, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE};
        len_new  = LEN_STATUS_MSG;
      end
      MSG_READ_REQ: begin
        body_new = {HOST_ADDR, own_addr, LEN_RES_REQ, OP_RES_REQ, RES_READ, {5{ZERO_BYTE}}};
        len_new  = LEN_REQ_MSG;
      end
      MSG_POWER_REQ: begin
        body_new = {HOST_ADDR, own_addr, LEN_RES_REQ, OP_RES_REQ, RES_POWER, {5{ZERO_BYTE}}};
        len_new  = LEN_REQ_MSG;
      end
    endcase
  end

  assign fire = frm_reg.active && tx_ready;

  always_comb begin
    frm_next = frm_reg;
    if (!frm_reg.active && start) begin
      frm_next.active = 1'b1;
      frm_next.idx    = 4'h0;
      frm_next.len    = len_new;
      frm_next.body   = {body_new[BODY_BYTES*8-9:0], ZERO_BYTE};
      frm_next.cur    = body_new[BODY_BYTES*8-1 -: 8];
      frm_next.xsum   = ZERO_BYTE;
    end else if (fire) begin
      frm_next.xsum = frm_reg.xsum ^ frm_reg.cur;
      frm_next.idx  = frm_reg.idx + 4'h1;
      frm_next.body = {frm_reg.body[BODY_BYTES*8-9:0], ZERO_BYTE};
      // Checksum closes the frame, xor of every byte before it
      frm_next.cur  = (frm_reg.idx + 4'h2 == frm_reg.len) ? (frm_reg.xsum ^ frm_reg.cur)
                                                          : frm_reg.body[BODY_BYTES*8-1 -: 8];
      if (frm_reg.idx + 4'h1 == frm_reg.len) begin
        frm_next.active = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frm_reg <= '0;
    end else begin
      frm_reg <= frm_next;
    end
  end

  assign tx_valid = frm_reg.active;
  assign tx_byte  = frm_reg.cur;
  assign tx_last  = frm_reg.active && (frm_reg.idx + 4'h1 == frm_reg.len);
  assign busy     = frm_reg.active;
endmodule : msg_framer

/* File: testbench/device_power_mode_manager_monitor.sv */
// Port checker for the power mode manager
`timescale 1ns/1ns
module device_power_mode_manager_monitor (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       rx_valid,
  input wire logic       rx_last,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_last,
  input wire logic       tx_ready,
  input wire logic       save_req,
  input wire logic       save_done,
  input wire logic       restore_busy,
  input wire logic       restore_revert,
  input wire logic [7:0] operating_mode_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic       got_frame;
  logic [3:0] tx_cnt;
  // Frame seen since shutdown began; cleared outside shutdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      got_frame <= 1'b0;
      tx_cnt    <= 4'h0;
    end else begin
      got_frame <= (operating_mode_code == 8'h03) && (got_frame || (rx_valid && rx_last));
      if (tx_valid && tx_ready) begin
        tx_cnt <= tx_last ? 4'h0 : tx_cnt + 4'h1;
      end
    end
  end
  mode_range_a: assert property (operating_mode_code <= 8'h04)
    else $error("mode code out of range");
  shut_hold_a: assert property ($past(operating_mode_code) == 8'h03 && operating_mode_code != 8'h03 |-> got_frame)
    else $error("shutdown left without a command");
  off_saved_a: assert property ($changed(operating_mode_code) && operating_mode_code == 8'h04 |-> $past(save_req))
    else $error("power off entered without save");
  save_end_a: assert property ($fell(save_req) |-> $past(save_done))
    else $error("save ended without save_done");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte dropped while stalled");
  msg_head_a: assert property ($rose(tx_valid) |-> tx_byte == 8'h50)
    else $error("message does not start with 50");
  msg_len_a: assert property (tx_valid && tx_last |-> tx_cnt inside {4'h5, 4'h8, 4'hA})
    else $error("message length wrong");
  msg_gap_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("no idle cycle after message");
  revert_once_a: assert property (restore_revert |=> !restore_revert)
    else $error("revert longer than one cycle");
  revert_cause_a: assert property (restore_revert |-> $past(restore_busy))
    else $error("revert without restore");
  cover property ($rose(save_req));
  cover property (restore_revert);
  cover property (tx_valid && tx_ready && tx_last && tx_cnt == 4'hA);
endmodule : device_power_mode_manager_monitor
bind device_power_mode_manager device_power_mode_manager_monitor mon (.clk, .rst, .rx_valid, .rx_last,
  .tx_valid, .tx_byte, .tx_last, .tx_ready, .save_req, .save_done, .restore_busy, .restore_revert,
  .operating_mode_code);

/* File: testbench/host_link_model.sv */
// Host side of the link: takes device messages with random stalls
`timescale 1ns/1ns
module host_link_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] got[$];
  int         n_msgs;
  // Stalls prove each byte is held until taken
  always @(negedge clk) tx_ready <= !rst && ($urandom % 3 != 0);
  // Every message is taken, power requests too
  // Bus power is never removed, so the wait after power off always holds
  always @(posedge clk) begin
    if (!rst && tx_valid && tx_ready) begin
      got.push_back(tx_byte);
      n_msgs += int'(tx_last);
    end
  end
endmodule : host_link_model

/* File: testbench/device_power_mode_manager_bench.sv */
// Self-checking bench for the power mode manager
`timescale 1ns/1ns
module device_power_mode_manager_bench;
  import pwr_mgmt_pkg::*;
  localparam int           CL  = 25;
  localparam logic [199:0] TAG = " pwr(run(B5 L9) psave(8))";
  logic        clk, rst, rx_valid, rx_first, rx_last, tx_valid, tx_last, tx_ready;
  logic        app_busy, auto_req, wake_event, save_done, state_at_host, restore_ok;
  logic        restore_fail, need_power, save_req, restore_busy, restore_revert;
  logic [7:0]  own_addr, rx_byte, tx_byte, auto_mode, cap_char, operating_mode_code;
  logic [15:0] bus_power_usage, line_power_usage;
  logic [5:0]  cap_index;
  logic [7:0]  q[$];
  int          fail_count, n_checks, cyc, m;
  device_power_mode_manager #(.CAP_LEN(CL), .CAP_TAG(TAG)) dut (.clk, .rst, .own_addr, .rx_valid,
    .rx_byte, .rx_first, .rx_last, .tx_valid, .tx_byte, .tx_last, .tx_ready, .app_busy, .auto_req,
    .auto_mode, .wake_event, .save_done, .state_at_host, .restore_ok, .restore_fail, .need_power,
    .bus_power_usage, .line_power_usage, .cap_index, .cap_char, .operating_mode_code, .save_req,
    .restore_busy, .restore_revert);
  host_link_model host (.clk, .rst, .tx_valid, .tx_byte, .tx_last, .tx_ready);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic send(input logic [7:0] c, input logic bad);
    logic [7:0] f[6];
    f = '{own_addr, HOST_ADDR, LEN_CMD, OP_CMD, c, 8'h00};
    f[5] = f[0] ^ f[1] ^ f[2] ^ f[3] ^ f[4] ^ {7'h00, bad};
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte  = f[i];
      rx_first = (i == 0);
      rx_last  = (i == 5);
    end
    @(negedge clk);
    {rx_valid, rx_first, rx_last} = 3'h0;
  endtask : send
  // Expected message in q; checksum sealed here
  task automatic expect_msg(input string s);
    logic [7:0] x;
    x = 8'h00;
    foreach (q[i]) x ^= q[i];
    q.push_back(x);
    for (int i = 0; i < 300 && host.got.size() < q.size(); i++) @(negedge clk);
    while (q.size() > 0) chk(s, q.pop_front(), host.got.size() > 0 ? host.got.pop_front() : 8'hxx);
  endtask : expect_msg
  task automatic wait_mode(input int e);
    for (int i = 0; i < 40 && operating_mode_code !== e[7:0]; i++) begin
      @(negedge clk);
      save_done = save_req;
    end
    save_done = 1'b0;
    m = e;
    chk("mode", m[7:0], operating_mode_code);
  endtask : wait_mode
  task automatic set_mode(input logic [7:0] c, input int e);
    send(c, 1'b0);
    wait_mode(e);
  endtask : set_mode
  task automatic query();
    bus_power_usage  = 16'(($urandom % 2) ? $urandom : 16'hFFFF);
    line_power_usage = 16'($urandom);
    send(CMD_QUERY, 1'b0);
    q = '{8'h50, own_addr, 8'h87, 8'hE6, 8'h00, m[7:0], bus_power_usage[15:8], bus_power_usage[7:0],
      line_power_usage[15:8], line_power_usage[7:0]};
    expect_msg("reply");
  endtask : query
  task automatic restart_req();
    state_at_host = 1'b1;
    send(CMD_RESTART, 1'b0);
    q = '{8'h50, own_addr, 8'h82, 8'hE5, 8'h05};
    expect_msg("read request");
    chk("restore_busy", 8'h01, {7'h00, restore_busy});
  endtask : restart_req
  initial begin
    void'($urandom(90));
    {rx_valid, rx_first, rx_last, app_busy, auto_req, wake_event, save_done} = 7'h00;
    {state_at_host, restore_ok, restore_fail, need_power} = 4'h0;
    {rx_byte, auto_mode, cap_index} = 22'h00_0000;
    own_addr = 8'h02 << ($urandom % 6);
    bus_power_usage  = 16'hFFFF;
    line_power_usage = 16'hFFFF;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    m = 2;
    chk("mode", 8'h02, operating_mode_code);
    query();
    app_busy = 1'b1;
    send(CMD_RUN, 1'b0);
    repeat (10) @(negedge clk);
    chk("mode", 8'h02, operating_mode_code);
    app_busy = 1'b0;
    wait_mode(0);
    auto_mode = 8'h01;
    auto_req  = 1'b1;
    wait_mode(1);
    auto_req = 1'b0;
    send(CMD_RUN, 1'b1);
    send(8'h07, 1'b0);
    repeat (10) @(negedge clk);
    chk("mode", 8'h01, operating_mode_code);
    $display("test basic modes done");
    set_mode(CMD_SHUTDOWN, 3);
    auto_mode  = 8'h00;
    auto_req   = 1'b1;
    wake_event = 1'b1;
    repeat (10) @(negedge clk);
    chk("mode", 8'h03, operating_mode_code);
    {auto_req, wake_event} = 2'h0;
    set_mode(CMD_SUSPEND, 2);
    wake_event = 1'b1;
    wait_mode(0);
    wake_event = 1'b0;
    set_mode(CMD_STANDBY, 1);
    set_mode(CMD_POWER_OFF, 4);
    query();
    $display("test low power done");
    need_power = 1'b1;
    q = '{8'h50, own_addr, 8'h82, 8'hE5, 8'h06};
    expect_msg("power request");
    need_power = 1'b0;
    restart_req();
    @(negedge clk) restore_fail = 1'b1;
    @(negedge clk) restore_fail = 1'b0;
    for (int i = 0; i < 10 && restore_revert !== 1'b1; i++) @(negedge clk);
    chk("restore_revert", 8'h01, {7'h00, restore_revert});
    q = '{8'h50, own_addr, 8'h85, 8'hA2, 8'h00, 8'h03, 8'h00, 8'h00};
    expect_msg("status");
    chk("mode", 8'h04, operating_mode_code);
    restart_req();
    @(negedge clk) restore_ok = 1'b1;
    @(negedge clk) restore_ok = 1'b0;
    wait_mode(0);
    chk("restore_busy", 8'h00, {7'h00, restore_busy});
    state_at_host = 1'b0;
    set_mode(CMD_SUSPEND, 2);
    set_mode(CMD_RESTART, 0);
    chk("restore_busy", 8'h00, {7'h00, restore_busy});
    $display("test restore done");
    for (int i = 0; i < CL; i++) begin
      @(negedge clk) cap_index = 6'(i);
      @(negedge clk) chk("cap_char", TAG[(CL-1-i)*8 +: 8], cap_char);
    end
    $display("test capability tag done");
    repeat (50) @(negedge clk);
    chk("spare bytes", 8'h00, 8'(host.got.size()));
    chk("messages", 8'h06, 8'(host.n_msgs));
    conclude();
  end
endmodule : device_power_mode_manager_bench
